// ===== inc/tsodr_pkg.sv
package tsodr_pkg;

	// ****************************************
	// register numbers
	// ****************************************
	localparam logic [7:0] REG_SECURITY_CONFIG = 8'h05;
	localparam logic [7:0] REG_RING_OSC_CONTROL = 8'h06;
	localparam logic [7:0] REG_RO_TILE_CELL = 8'h07;
	localparam logic [7:0] REG_RO_TILE_WIRE = 8'h08;
	localparam logic [7:0] REG_RO_PERIPH_CELL = 8'h09;
	localparam logic [7:0] REG_RO_PERIPH_WIRE = 8'h0a;
	localparam logic [7:0] REG_RAM_SIZE = 8'h0c;
	localparam logic [7:0] REG_DEBUG_SAVED_STATUS = 8'h10;
	localparam logic [7:0] REG_DEBUG_SAVED_PC = 8'h11;
	localparam logic [7:0] REG_DEBUG_SAVED_SP = 8'h12;
	localparam logic [7:0] REG_DEBUG_READ_THREAD_SEL = 8'h13;
	localparam logic [7:0] REG_DEBUG_READ_REG_SEL = 8'h14;
	localparam logic [7:0] REG_DEBUG_IRQ_CAUSE = 8'h15;

	// ****************************************
	// field positions and masks
	// ****************************************
	localparam int SEC_WRITE_LOCK_BIT = 31;
	localparam int SEC_GLOBAL_DBG_DIS_BIT = 14;
	localparam int SEC_LOCK_ALL_BIT = 12;
	localparam int SEC_SECTOR_LOCK_LSB = 8;
	localparam int SEC_OTP_REDUNDANCY_BIT = 7;
	localparam int SEC_BOOT_FROM_OTP_BIT = 5;
	localparam int SEC_JTAG_CFG_DIS_BIT = 4;
	localparam int SEC_JTAG_TAP_DIS_BIT = 0;
	localparam logic [31:0] SEC_WRITABLE_MASK = 32'h8000_5fb1;
	localparam int ROSC_CORE_EN_BIT = 1;
	localparam int ROSC_PERIPH_EN_BIT = 0;
	localparam logic [31:0] SSR_WRITABLE_MASK = 32'h0000_06df;
	localparam logic [31:0] CAUSE_WRITABLE_MASK = 32'h0003_ff07;

	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic [1:0] ROSC_CONTROL_RESET = 2'h0;
	localparam logic [2:0] CAUSE_RESET = 3'h0;
	localparam logic [31:0] RAM_SIZE_BYTES = 32'h0002_0000;
	localparam int ROSC_STOP_SETTLE_CYCLES = 10;

	// ****************************************
	// debug entry causes
	// ****************************************
	localparam logic [2:0] CAUSE_HOST = 3'h1;
	localparam logic [2:0] CAUSE_DEBUG_CALL_INSTR = 3'h2;
	localparam logic [2:0] CAUSE_IBREAK = 3'h3;
	localparam logic [2:0] CAUSE_DWATCH = 3'h4;
	localparam logic [2:0] CAUSE_RWATCH = 3'h5;

	typedef struct packed
	{
		logic [31:0] saved_status_word;
		logic [31:0] saved_program_counter;
		logic [31:0] saved_stack_pointer;
		logic [2:0] cause;
		logic [3:0] hw_point_hits;
		logic [7:0] thread;
	} tsodr_dbg_entry_t;

	typedef struct packed
	{
		logic global_debug_dis;
		logic lock_all_sectors;
		logic [3:0] sector_lock;
		logic otp_redundancy_en;
		logic boot_from_otp;
		logic jtag_cfg_dis;
		logic jtag_tap_dis;
	} tsodr_sec_ctrl_t;

endpackage

// ===== rtl/tsodr_regs.sv
`timescale 1ns/1ps
// Contract
// R01: security register loaded from OTP word
// R02: bit 31 blocks further security writes
// R03: bit 14 denies global debug access
// R04: bits 12, 11:8 lock sectors; 7 redundancy
// R05: bit 5 forces boot from OTP
// R06: bit 4 refuses JTAG PLL/boot access
// R07: bit 0 refuses JTAG debug TAP
// R08: four oscillators clock counters, software start/stop
// R09: control bits 1 core, 0 periph; reset 0
// R10: software reads counts after 10-cycle stop
// R11: oscillators asynchronous, usable as random bits
// R12: four 16-bit counts at 0x07..0x0A
// R13: counters survive system reset
// R14: read-only RAM size bits 31:2
// R15: debug entry captures status word
// R16: status bits 0..4 event/int/seq/handler/kernel
// R17: status bits 6..10 pause/fast/issue/entry/asid
// R18: debug entry captures pc and sp
// R19: read op thread 7:0, register 4:0
// R20: cause code bits 2:0, reset zero
// R21: lowest hardware point number, else zero
// R22: causing thread bits 15:8, host zero
// R23: counters wrap on edges, hold when stopped
module tsodr_regs
	import tsodr_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// processor status access
	input wire logic i_ps_wr,
	input wire logic i_ps_rd,
	input wire logic i_ps_dbg_mode,
	input wire logic [7:0] i_ps_reg,
	input wire logic [31:0] i_ps_wdata,
	output logic [31:0] o_ps_rdata,
	output logic o_ps_ack,
	// one-time-programmable security word
	input wire logic i_otp_sec_valid,
	input wire logic [31:0] i_otp_sec_word,
	// ring oscillators, each its own clock
	input wire logic [3:0] i_rosc_clk,
	output logic o_rosc_core_en,
	output logic o_rosc_periph_en,
	// debug entry
	input wire logic i_dbg_enter,
	input wire tsodr_dbg_entry_t i_dbg_entry,
	// security controls
	output tsodr_sec_ctrl_t o_sec_ctrl,
	// debug register read operands
	output logic [7:0] o_dbg_read_thread,
	output logic [4:0] o_dbg_read_reg
);

	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// decode
	// ****************************************
	wire wr_sec = i_ps_wr && i_ps_reg == REG_SECURITY_CONFIG;
	wire wr_rosc = i_ps_wr && i_ps_reg == REG_RING_OSC_CONTROL;
	// debug-only registers need debug mode for writes
	wire dbg_wr = i_ps_wr && i_ps_dbg_mode;
	wire wr_ssr = dbg_wr && i_ps_reg == REG_DEBUG_SAVED_STATUS;
	wire wr_spc = dbg_wr && i_ps_reg == REG_DEBUG_SAVED_PC;
	wire wr_ssp = dbg_wr && i_ps_reg == REG_DEBUG_SAVED_SP;
	wire wr_tsel = dbg_wr && i_ps_reg == REG_DEBUG_READ_THREAD_SEL;
	wire wr_rsel = dbg_wr && i_ps_reg == REG_DEBUG_READ_REG_SEL;
	wire wr_cause = dbg_wr && i_ps_reg == REG_DEBUG_IRQ_CAUSE;

	// ****************************************
	// security configuration
	// ****************************************
	logic [31:0] sec_reg;
	logic [31:0] sec_next;
	logic sec_loaded_reg;

	// otp copy wins once; afterwards software writes until locked
	always_comb
	begin
		sec_next = sec_reg;
		if (i_otp_sec_valid && !sec_loaded_reg)
			sec_next = i_otp_sec_word & SEC_WRITABLE_MASK; // [R01]
		else if (wr_sec && !sec_reg[SEC_WRITE_LOCK_BIT]) // [R02]
			sec_next = i_ps_wdata & SEC_WRITABLE_MASK;
	end

	// most secure state until the otp word arrives
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec_reg <= SEC_WRITABLE_MASK;
			sec_loaded_reg <= 1'b0;
		end
		else
		begin
			sec_reg <= sec_next;
			sec_loaded_reg <= sec_loaded_reg | i_otp_sec_valid;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_sec_ctrl <= '1;
		else
		begin
			o_sec_ctrl.global_debug_dis <=
				sec_reg[SEC_GLOBAL_DBG_DIS_BIT]; // [R03]
			o_sec_ctrl.lock_all_sectors <=
				sec_reg[SEC_LOCK_ALL_BIT]; // [R04]
			o_sec_ctrl.sector_lock <= sec_reg[SEC_SECTOR_LOCK_LSB+:4]
				| {4{sec_reg[SEC_LOCK_ALL_BIT]}}; // [R04]
			o_sec_ctrl.otp_redundancy_en <=
				sec_reg[SEC_OTP_REDUNDANCY_BIT]; // [R04]
			o_sec_ctrl.boot_from_otp <=
				sec_reg[SEC_BOOT_FROM_OTP_BIT]; // [R05]
			o_sec_ctrl.jtag_cfg_dis <= sec_reg[SEC_JTAG_CFG_DIS_BIT]; // [R06]
			o_sec_ctrl.jtag_tap_dis <= sec_reg[SEC_JTAG_TAP_DIS_BIT]; // [R07]
		end
	end

	// ****************************************
	// ring oscillator control and counters
	// ****************************************
	logic [1:0] rosc_ctl_reg;

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rosc_ctl_reg <= ROSC_CONTROL_RESET; // [R09]
		else if (wr_rosc)
			rosc_ctl_reg <= i_ps_wdata[1:0]; // [R08]
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_rosc_core_en <= 1'b0;
			o_rosc_periph_en <= 1'b0;
		end
		else
		begin
			o_rosc_core_en <= rosc_ctl_reg[ROSC_CORE_EN_BIT]; // [R09]
			o_rosc_periph_en <= rosc_ctl_reg[ROSC_PERIPH_EN_BIT]; // [R09]
		end
	end

	// tile pair follows core enable, periph pair the periph enable
	wire [3:0] rosc_en = {{2{rosc_ctl_reg[ROSC_PERIPH_EN_BIT]}},
		{2{rosc_ctl_reg[ROSC_CORE_EN_BIT]}}};
	logic [15:0] rosc_cnt [4];

	// counts are read raw: only stable once stopped for a while
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_rosc
			logic [2:0] en_sync_reg;
			// power-up value only; a system reset never touches it
			logic [15:0] cnt_reg = 16'h0000;

			// no reset at all so a system reset keeps the count
			always_ff @(posedge i_rosc_clk[g]) // [R11] [R13]
			begin
				en_sync_reg <= {en_sync_reg[1:0], rosc_en[g]};
				if (en_sync_reg[1] && en_sync_reg[2])
					cnt_reg <= cnt_reg + 16'h0001; // [R23]
			end
			assign rosc_cnt[g] = cnt_reg; // [R10]
		end
	endgenerate

	// ****************************************
	// debug state capture
	// ****************************************
	logic [31:0] ssr_reg;
	logic [31:0] spc_reg;
	logic [31:0] ssp_reg;
	logic [7:0] tsel_reg;
	logic [4:0] rsel_reg;
	logic [31:0] cause_reg;
	logic [31:0] cause_next;
	logic [1:0] hit_num;

	// lowest numbered hardware point wins
	assign hit_num = i_dbg_entry.hw_point_hits[0] ? 2'h0 :
		i_dbg_entry.hw_point_hits[1] ? 2'h1 :
		i_dbg_entry.hw_point_hits[2] ? 2'h2 :
		i_dbg_entry.hw_point_hits[3] ? 2'h3 : 2'h0; // [R21]

	wire cause_sw = i_dbg_entry.cause == CAUSE_HOST ||
		i_dbg_entry.cause == CAUSE_DEBUG_CALL_INSTR;

	// capture beats a simultaneous software write
	always_comb
	begin
		cause_next = cause_reg;
		if (i_dbg_enter)
		begin
			cause_next = 32'h0;
			cause_next[2:0] = i_dbg_entry.cause; // [R20]
			cause_next[17:16] = cause_sw ? 2'h0 : hit_num; // [R21]
			cause_next[15:8] = (i_dbg_entry.cause == CAUSE_HOST) ?
				8'h00 : i_dbg_entry.thread; // [R22]
		end
		else if (wr_cause)
			cause_next = i_ps_wdata & CAUSE_WRITABLE_MASK;
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cause_reg <= {29'h0, CAUSE_RESET}; // [R20]
		else
			cause_reg <= cause_next;
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssr_reg <= 32'h0;
			spc_reg <= 32'h0;
			ssp_reg <= 32'h0;
		end
		else if (i_dbg_enter)
		begin
			// bit 8 is read-only for software but still captured
			ssr_reg <= i_dbg_entry.saved_status_word
				& (SSR_WRITABLE_MASK | 32'h0000_0100); // [R15] [R16] [R17]
			spc_reg <= i_dbg_entry.saved_program_counter; // [R18]
			ssp_reg <= i_dbg_entry.saved_stack_pointer; // [R18]
		end
		else
		begin
			// bit 8 follows capture only, software cannot change it
			if (wr_ssr)
				ssr_reg <= (i_ps_wdata & SSR_WRITABLE_MASK
					& ~32'h0000_0100) | (ssr_reg & 32'h0000_0100);
			if (wr_spc)
				spc_reg <= i_ps_wdata;
			if (wr_ssp)
				ssp_reg <= i_ps_wdata;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tsel_reg <= 8'h00;
			rsel_reg <= 5'h00;
		end
		else
		begin
			if (wr_tsel)
				tsel_reg <= i_ps_wdata[7:0]; // [R19]
			if (wr_rsel)
				rsel_reg <= i_ps_wdata[4:0]; // [R19]
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_dbg_read_thread <= 8'h00;
			o_dbg_read_reg <= 5'h00;
		end
		else
		begin
			o_dbg_read_thread <= tsel_reg; // [R19]
			o_dbg_read_reg <= rsel_reg; // [R19]
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	logic [31:0] rd_mux;

	always_comb
	begin
		case (i_ps_reg)
			REG_SECURITY_CONFIG: rd_mux = sec_reg;
			REG_RING_OSC_CONTROL: rd_mux = {30'h0, rosc_ctl_reg};
			REG_RO_TILE_CELL: rd_mux = {16'h0, rosc_cnt[0]}; // [R12]
			REG_RO_TILE_WIRE: rd_mux = {16'h0, rosc_cnt[1]}; // [R12]
			REG_RO_PERIPH_CELL: rd_mux = {16'h0, rosc_cnt[2]}; // [R12]
			REG_RO_PERIPH_WIRE: rd_mux = {16'h0, rosc_cnt[3]}; // [R12]
			REG_RAM_SIZE: rd_mux = RAM_SIZE_BYTES & ~32'h3; // [R14]
			REG_DEBUG_SAVED_STATUS: rd_mux = ssr_reg;
			REG_DEBUG_SAVED_PC: rd_mux = spc_reg;
			REG_DEBUG_SAVED_SP: rd_mux = ssp_reg;
			REG_DEBUG_READ_THREAD_SEL: rd_mux = {24'h0, tsel_reg};
			REG_DEBUG_READ_REG_SEL: rd_mux = {27'h0, rsel_reg};
			REG_DEBUG_IRQ_CAUSE: rd_mux = cause_reg;
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_ps_rdata <= 32'h0;
			o_ps_ack <= 1'b0;
		end
		else
		begin
			o_ps_ack <= i_ps_rd | i_ps_wr;
			if (i_ps_rd)
				o_ps_rdata <= rd_mux;
		end
	end

endmodule

// ===== test/tsodr_regs_chk.sv
`timescale 1ns/1ps
module tsodr_regs_chk
	import tsodr_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_ps_wr,
	input wire logic i_ps_rd,
	input wire logic i_ps_dbg_mode,
	input wire logic [7:0] i_ps_reg,
	input wire logic [31:0] i_ps_wdata,
	input wire logic [31:0] o_ps_rdata,
	input wire logic o_ps_ack,
	input wire logic o_rosc_core_en,
	input wire logic i_dbg_enter,
	input wire tsodr_dbg_entry_t i_dbg_entry,
	input wire tsodr_sec_ctrl_t o_sec_ctrl,
	input wire logic [7:0] o_dbg_read_thread
);
	// ********
	// checks
	// ********
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	wire logic req = i_ps_rd | i_ps_wr;
	sequence rd_after_entry(logic [7:0] r);
		i_dbg_enter ##2 (i_ps_rd && i_ps_reg == r);
	endsequence
	AST_ACK: assert property (req |=> o_ps_ack ##1 (!o_ps_ack || $past(req))) else $error("ack not one cycle");
	AST_RAM: assert property (i_ps_rd && i_ps_reg == 8'h0c |=> o_ps_rdata == 32'h0002_0000) else $error("ram size");
	AST_CNT_HI: assert property (i_ps_rd && i_ps_reg inside {[8'h07:8'h0a]} |=> o_ps_rdata[31:16] == 16'h0) else $error("count upper bits");
	AST_SSR: assert property (i_dbg_enter ##4 (i_ps_rd && i_ps_reg == 8'h10) |=> o_ps_rdata == ($past(i_dbg_entry.saved_status_word, 5) & 32'h7df)) else $error("status capture");
	AST_PC: assert property (i_dbg_enter ##8 (i_ps_rd && i_ps_reg == 8'h11) |=> o_ps_rdata == $past(i_dbg_entry.saved_program_counter, 9)) else $error("pc capture");
	AST_CAUSE: assert property (rd_after_entry(8'h15) |=> o_ps_rdata[2:0] == $past(i_dbg_entry.cause, 3)) else $error("cause capture");
	AST_HOST_HIT: assert property (i_dbg_enter && i_dbg_entry.cause inside {3'h1, 3'h2} ##2 (i_ps_rd && i_ps_reg == 8'h15) |=> o_ps_rdata[17:16] == 2'h0) else $error("hit not zero");
	AST_SEC_OUT: assert property (i_ps_rd && i_ps_reg == 8'h05 |=> o_sec_ctrl.jtag_tap_dis == o_ps_rdata[0] && o_sec_ctrl.global_debug_dis == o_ps_rdata[14]) else $error("security outputs");
	AST_ROSC: assert property (i_ps_wr && i_ps_reg == 8'h06 ##1 !i_ps_wr |=> o_rosc_core_en == $past(i_ps_wdata[1], 2)) else $error("osc enable");
	AST_THREAD: assert property (i_ps_wr && i_ps_dbg_mode && i_ps_reg == 8'h13 ##1 !i_ps_wr |=> o_dbg_read_thread == $past(i_ps_wdata[7:0], 2)) else $error("thread operand");
	COV_ENTRY: cover property (rd_after_entry(8'h15));
	COV_LOCK: cover property (i_ps_wr && i_ps_reg == 8'h05);
	COV_ROSC: cover property ($fell(o_rosc_core_en));
endmodule

bind tsodr_regs tsodr_regs_chk i_tsodr_regs_chk (.i_sys_clk(i_sys_clk),
	.i_arst_n(i_arst_n), .i_ps_wr(i_ps_wr), .i_ps_rd(i_ps_rd),
	.i_ps_dbg_mode(i_ps_dbg_mode),
	.i_ps_reg(i_ps_reg), .i_ps_wdata(i_ps_wdata), .o_ps_rdata(o_ps_rdata),
	.o_ps_ack(o_ps_ack), .o_rosc_core_en(o_rosc_core_en),
	.i_dbg_enter(i_dbg_enter), .i_dbg_entry(i_dbg_entry),
	.o_sec_ctrl(o_sec_ctrl), .o_dbg_read_thread(o_dbg_read_thread));

// ===== test/tsodr_far_model.sv
`timescale 1ns/1ps
module tsodr_far_model
(
	input wire logic i_sys_clk,
	input wire logic i_load,
	input wire logic [31:0] i_word,
	output logic o_otp_valid,
	output logic [31:0] o_otp_word,
	output logic [3:0] o_rosc_clk
);
	// ********
	// oscillators and security word
	// ********
	// periods unrelated to the core clock, never stopped
	initial o_rosc_clk = 4'h0;
	always #3.1 o_rosc_clk[0] = ~o_rosc_clk[0];
	always #3.7 o_rosc_clk[1] = ~o_rosc_clk[1];
	always #4.3 o_rosc_clk[2] = ~o_rosc_clk[2];
	always #5.9 o_rosc_clk[3] = ~o_rosc_clk[3];
	initial o_otp_valid = 1'b0;
	always @(posedge i_sys_clk)
		o_otp_valid <= #1 i_load;
	// word only meaningful while valid; inverted otherwise
	assign o_otp_word = o_otp_valid ? i_word : ~i_word;
endmodule

// ===== test/tsodr_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tsodr_regs_tb;
	import tsodr_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, dmode = 0, ent = 0, load = 0;
	logic [7:0] rg = 8'h0, thr;
	logic [31:0] wd = 32'h0, rdata, q, otp_word, sec;
	logic ack, core_en, per_en, valid;
	logic [3:0] rosc;
	logic [4:0] sel_reg;
	tsodr_dbg_entry_t entry = '0;
	tsodr_sec_ctrl_t sctl;
	int errors = 0, tests_run = 0;
	logic [1:0] hit;
	logic [7:0] t;
	logic [31:0] snap [4];
	typedef struct {logic w; logic [7:0] r; logic [31:0] d, e;} row_t;
	row_t rows [8] = '{
		'{1'b0, 8'h0c, 32'h0, 32'h0002_0000},
		'{1'b1, 8'h0c, 32'hffff_ffff, 32'h0002_0000},
		'{1'b1, 8'h06, 32'hffff_ffff, 32'h3},
		'{1'b1, 8'h13, 32'hffff_ffff, 32'hff},
		'{1'b1, 8'h14, 32'hffff_ffff, 32'h1f},
		'{1'b1, 8'h15, 32'hffff_ffff, 32'h3ff07},
		'{1'b1, 8'h10, 32'hffff_ffff, 32'h6df},
		'{1'b1, 8'h20, 32'hffff_ffff, 32'h0}};
	always #5 clk = ~clk;
	tsodr_far_model i_tsodr_far_model (.i_sys_clk(clk), .i_load(load),
		.i_word(otp_word), .o_otp_valid(valid), .o_otp_word(sec),
		.o_rosc_clk(rosc));
	tsodr_regs i_tsodr_regs (.i_sys_clk(clk), .i_arst_n(rst_n),
		.i_ps_wr(wr), .i_ps_rd(rd), .i_ps_dbg_mode(dmode), .i_ps_reg(rg),
		.i_ps_wdata(wd), .o_ps_rdata(rdata), .o_ps_ack(ack),
		.i_otp_sec_valid(valid), .i_otp_sec_word(sec), .i_rosc_clk(rosc),
		.o_rosc_core_en(core_en), .o_rosc_periph_en(per_en),
		.i_dbg_enter(ent), .i_dbg_entry(entry), .o_sec_ctrl(sctl),
		.o_dbg_read_thread(thr), .o_dbg_read_reg(sel_reg));
	task automatic ps(input logic w, input logic [7:0] r,
		input logic [31:0] d, output logic [31:0] o);
		@(posedge clk);
		#1 wr = w;
		rd = !w;
		rg = r;
		wd = d;
		@(posedge clk);
		#1 wr = 0;
		rd = 0;
		o = rdata;
		`CHK(ack, 1'b1)
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		close_out();
	end
	initial
	begin
		otp_word = 32'h0000_5031;
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		repeat (3) @(posedge clk);
		ps(0, 8'h06, 0, q);
		`CHK(q, 32'h0)
		ps(0, 8'h15, 0, q);
		`CHK(q[2:0], 3'h0)
		#1 load = 1;
		@(posedge clk);
		#1 load = 0;
		repeat (3) @(posedge clk);
		ps(0, 8'h05, 0, q);
		`CHK(q, 32'h0000_5031)
		`CHK({sctl.global_debug_dis, sctl.lock_all_sectors}, 2'h3)
		`CHK({sctl.sector_lock, sctl.boot_from_otp}, 5'h1f)
		`CHK({sctl.jtag_cfg_dis, sctl.jtag_tap_dis}, 2'h3)
		ps(1, 8'h05, 32'h8000_0180, q);
		ps(1, 8'h05, 32'h0, q);
		ps(0, 8'h05, 0, q);
		`CHK(q, 32'h8000_0180)
		`CHK({sctl.sector_lock, sctl.otp_redundancy_en}, 5'h3)
		ps(1, 8'h11, 32'h1234_5678, q);
		dmode = 1;
		foreach (rows[i])
		begin
			ps(rows[i].w, rows[i].r, rows[i].d, q);
			ps(0, rows[i].r, 0, q);
			`CHK(q, rows[i].e)
		end
		`CHK({thr, sel_reg}, 13'h1fff)
		ps(0, 8'h11, 0, q);
		`CHK(q, 32'h0)
		for (int c = 1; c <= 5; c++)
		begin
			@(posedge clk);
			#1 ent = 1;
			entry = '{32'hffff_ffff, 32'hc0de_0000 + c, 32'h5ac0_0000 + c,
				c[2:0], 4'b0110, 8'h40 + c[7:0]};
			@(posedge clk);
			#1 ent = 0;
			hit = c >= 3 ? 2'h1 : 2'h0;
			t = c == 1 ? 8'h0 : 8'h40 + c[7:0];
			ps(0, 8'h15, 0, q);
			`CHK(q, {14'h0, hit, t, 5'h0, c[2:0]})
			ps(0, 8'h10, 0, q);
			`CHK(q, 32'h7df)
			ps(0, 8'h12, 0, q);
			`CHK(q, 32'h5ac0_0000 + c)
			ps(0, 8'h11, 0, q);
			`CHK(q, 32'hc0de_0000 + c)
		end
		ps(1, 8'h06, 32'h0, q);
		// stopped counters need ten cycles to settle
		repeat (12) @(posedge clk);
		for (int k = 0; k < 4; k++)
		begin
			ps(0, 8'h07 + k[7:0], 0, snap[k]);
			`CHK(snap[k] != 32'h0, 1'b1)
		end
		rst_n = 0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		repeat (40) @(posedge clk);
		for (int k = 0; k < 4; k++)
		begin
			ps(0, 8'h07 + k[7:0], 0, q);
			`CHK(q, snap[k])
		end
		close_out();
	end
endmodule
